/* File: rtl/gpclr_pkg.sv */
/*
  gpclr_pkg: constants, register map and packed carriers for the 32-pin
  output-clear / pin-write port block.
  assumes: one AXI4-Lite slave with 32-bit data, byte addresses as printed.
*/
`default_nettype none
package gpclr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned GPCLR_AW = 32;
  localparam int unsigned GPCLR_DW = 32;

  ////////////////////////////////////////////////////////////////////////
  // legacy path register byte addresses (peripheral bus)
  localparam logic [31:0] GPCLR_LEG_PIN_ADDR   = 32'hE002_8000;
  localparam logic [31:0] GPCLR_LEG_SET_ADDR   = 32'hE002_8004;
  localparam logic [31:0] GPCLR_LEG_DIR_ADDR   = 32'hE002_8008;
  localparam logic [31:0] GPCLR_LEG_CLR_ADDR   = 32'hE002_800C;
  localparam logic [31:0] GPCLR_FUNC_ADDR      = 32'hE002_8010;
  // fast path; byte and half registers are lanes of these words
  localparam logic [31:0] GPCLR_FAST_DIR_ADDR  = 32'h3FFF_C000;
  localparam logic [31:0] GPCLR_FAST_MASK_ADDR = 32'h3FFF_C010;
  localparam logic [31:0] GPCLR_FAST_PIN_ADDR  = 32'h3FFF_C014;
  localparam logic [31:0] GPCLR_FAST_SET_ADDR  = 32'h3FFF_C018;
  localparam logic [31:0] GPCLR_FAST_CLR_ADDR  = 32'h3FFF_C01C;
  localparam logic [31:0] GPCLR_FAST_CLR_B1    = 32'h3FFF_C01D;
  localparam logic [31:0] GPCLR_FAST_CLR_B2    = 32'h3FFF_C01E;
  localparam logic [31:0] GPCLR_FAST_CLR_B3    = 32'h3FFF_C01F;

  ////////////////////////////////////////////////////////////////////////
  // reset values and responses
  localparam logic [31:0] GPCLR_RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  GPCLR_RESP_OK  = 2'h0;
  localparam logic [1:0]  GPCLR_RESP_ERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // bus carriers
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } gpclr_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } gpclr_axil_rsp_t;

  // all state of the top module
  typedef struct packed {
    logic        aw_vld;
    logic        aw_rdy;
    logic [31:0] aw_addr;
    logic        w_vld;
    logic        w_rdy;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        b_vld;
    logic [1:0]  b_resp;
    logic        ar_rdy;
    logic        r_vld;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic [31:0] dir;
    logic [31:0] mask;
    logic [31:0] func;
    logic [31:0] outv;
    logic [31:0] oe;
  } gpclr_state_t;

endpackage
`default_nettype wire

/* File: rtl/gpclr_port.sv */
/*
  gpclr_port: 32-pin port output latch with legacy and fast set, clear and
  pin-value writes, fast access mask, direction and pin function registers.
  assumes: AXI4-Lite master on aclk, gpio_in synchronous to aclk, pad logic
  outside combines gpio_out and gpio_oe.
*/
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
// Summary of operation
// RULE1 - clear write one drives output pin low and clears its set bit
// RULE2 - clear bits written zero leave pins and set bits unchanged
// RULE3 - clear has no effect on input or secondary-function pins
// RULE4 - fast clear acts only on pins unmasked by the fast mask
// RULE5 - legacy and fast clear are 32 bits, bit n is pin n, reset zero
// RULE6 - four byte lanes of fast clear cover pins 7:0 up to 31:24
// RULE7 - lower and upper half lanes of fast clear cover 15:0 and 31:16
// RULE8 - latest set or clear write decides the output pin level
// RULE9 - each write acts on its own access, so clear follows set later
// RULE10 - pin-value write drives all output pins to the written pattern
// RULE11 - with mask FFFF00FF a fast pin write changes only pins 15:8
// RULE12 - half mask and half pin-value give the same masked write
// RULE13 - byte write to fast pin lane one updates only pins 15:8
// RULE14 - software does read-modify-write for partial legacy pin writes
// RULE15 - set write one drives output pin high, zeros have no effect
// RULE16 - set register reads back the output latch, not the pin level
// RULE17 - only pins with mask bit zero are reachable on fast registers; here fast direction writes and reads ignore the mask
// RULE18 - partial fast clear writes affect only written byte lanes
module gpclr_port
  import gpclr_pkg::*;
#(
  parameter int unsigned PINS = 32
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire gpclr_axil_req_t  axil_req,
  output var  gpclr_axil_rsp_t  axil_rsp,
  input  wire logic [31:0]      gpio_in,
  output logic      [31:0]      gpio_out,
  output logic      [31:0]      gpio_oe
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration check: the map holds exactly one 32-pin port
  if (PINS != GPCLR_DW) begin : g_pins_check
    $error("gpclr_port serves only 32 pins");
  end

  localparam gpclr_state_t RST = '{
    aw_vld: 1'b0, aw_rdy: 1'b0, aw_addr: GPCLR_RST_WORD,
    w_vld: 1'b0, w_rdy: 1'b0, w_data: GPCLR_RST_WORD, w_strb: 4'h0,
    b_vld: 1'b0, b_resp: GPCLR_RESP_OK, ar_rdy: 1'b0, r_vld: 1'b0,
    r_data: GPCLR_RST_WORD, r_resp: GPCLR_RESP_OK, dir: GPCLR_RST_WORD,
    mask: GPCLR_RST_WORD, func: GPCLR_RST_WORD, outv: GPCLR_RST_WORD,
    oe: GPCLR_RST_WORD};

  gpclr_state_t q;
  gpclr_state_t d;

  logic        wr_go;
  logic [29:0] wr_word;
  logic [29:0] rd_word;
  logic [31:0] lanes;
  logic [31:0] gpo;
  logic [31:0] fast_ok;
  logic [31:0] set_m;
  logic [31:0] clr_m;
  logic [31:0] pin_m;
  logic [31:0] pin_lvl;
  logic        is_leg_clr;
  logic        is_fast_clr;

  ////////////////////////////////////////////////////////////////////////
  // byte strobes widened to one enable per pin; this is how byte and half
  // registers at the printed sub-word addresses reach their own lanes
  for (genvar i = 0; i < 32; i++) begin : g_lane
    assign lanes[i] = q.w_strb[i / 8];
  end

  // write decode and per-pin masks of the pending write
  always_comb begin
    wr_go       = q.aw_vld && q.w_vld && !q.b_vld;
    wr_word     = q.aw_addr[31:2];
    rd_word     = axil_req.araddr[31:2];
    gpo         = q.dir & ~q.func; // only gpio outputs follow writes [RULE3]
    fast_ok     = ~q.mask; // zero in mask means reachable [RULE17]
    is_leg_clr  = wr_word == GPCLR_LEG_CLR_ADDR[31:2];
    is_fast_clr = wr_word == GPCLR_FAST_CLR_ADDR[31:2];
    pin_lvl     = (q.outv & gpo) | (gpio_in & ~gpo);
    set_m       = q.w_data & lanes & gpo; // [RULE15]
    clr_m       = q.w_data & lanes & gpo; // [RULE1] [RULE2] [RULE6] [RULE7]
    pin_m       = lanes & gpo; // [RULE10] [RULE13]
    if (wr_word[29:4] == GPCLR_FAST_DIR_ADDR[31:6]) begin
      set_m = set_m & fast_ok; // [RULE4]
      clr_m = clr_m & fast_ok; // [RULE4] [RULE18]
      pin_m = pin_m & fast_ok; // [RULE11] [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: bus handshakes and register effects
  always_comb begin
    d = q;
    // address and data channels are taken independently, in either order
    if (axil_req.awvalid && q.aw_rdy) begin
      d.aw_vld  = 1'b1;
      d.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && q.w_rdy) begin
      d.w_vld  = 1'b1;
      d.w_data = axil_req.wdata;
      d.w_strb = axil_req.wstrb;
    end
    if (q.b_vld && axil_req.bready) begin
      d.b_vld = 1'b0;
    end
    // each write acts alone on its own cycle, later writes win [RULE8]
    if (wr_go) begin // [RULE9]
      d.aw_vld = 1'b0;
      d.w_vld  = 1'b0;
      d.b_vld  = 1'b1;
      d.b_resp = GPCLR_RESP_OK;
      case (wr_word)
        GPCLR_LEG_SET_ADDR[31:2], GPCLR_FAST_SET_ADDR[31:2]: begin
          d.outv = q.outv | set_m; // [RULE15]
        end
        GPCLR_LEG_CLR_ADDR[31:2], GPCLR_FAST_CLR_ADDR[31:2]: begin
          d.outv = q.outv & ~clr_m; // set bit is the latch bit [RULE1]
        end
        GPCLR_LEG_PIN_ADDR[31:2], GPCLR_FAST_PIN_ADDR[31:2]: begin
          d.outv = (q.outv & ~pin_m) | (q.w_data & pin_m); // [RULE10]
        end
        GPCLR_LEG_DIR_ADDR[31:2], GPCLR_FAST_DIR_ADDR[31:2]: begin
          d.dir = (q.dir & ~lanes) | (q.w_data & lanes);
        end
        GPCLR_FAST_MASK_ADDR[31:2]: begin
          d.mask = (q.mask & ~lanes) | (q.w_data & lanes);
        end
        GPCLR_FUNC_ADDR[31:2]: begin
          d.func = (q.func & ~lanes) | (q.w_data & lanes);
        end
        default: begin
          d.b_resp = GPCLR_RESP_ERR; // unmapped: no effect, error answer
        end
      endcase
    end
    // read: one outstanding, answered the cycle after it is taken
    if (q.r_vld && axil_req.rready) begin
      d.r_vld = 1'b0;
    end
    if (axil_req.arvalid && q.ar_rdy) begin
      d.r_vld  = 1'b1;
      d.r_resp = GPCLR_RESP_OK;
      case (rd_word)
        GPCLR_LEG_SET_ADDR[31:2]: d.r_data = q.outv; // latch [RULE16]
        GPCLR_FAST_SET_ADDR[31:2]: d.r_data = q.outv & fast_ok;
        GPCLR_LEG_PIN_ADDR[31:2]: d.r_data = pin_lvl;
        GPCLR_FAST_PIN_ADDR[31:2]: d.r_data = pin_lvl & fast_ok;
        GPCLR_LEG_DIR_ADDR[31:2], GPCLR_FAST_DIR_ADDR[31:2]: begin
          d.r_data = q.dir;
        end
        GPCLR_FAST_MASK_ADDR[31:2]: d.r_data = q.mask;
        GPCLR_FUNC_ADDR[31:2]: d.r_data = q.func;
        // clear words are write-only and read back their reset zero
        GPCLR_LEG_CLR_ADDR[31:2], GPCLR_FAST_CLR_ADDR[31:2]: begin
          d.r_data = GPCLR_RST_WORD; // [RULE5]
        end
        default: begin
          d.r_data = GPCLR_RST_WORD;
          d.r_resp = GPCLR_RESP_ERR;
        end
      endcase
    end
    // ready flags are registered so every bus output comes from a flop
    d.aw_rdy = !d.aw_vld;
    d.w_rdy  = !d.w_vld;
    d.ar_rdy = !d.r_vld;
    d.oe     = d.dir & ~d.func;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST; // [RULE5]
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, straight from the state flops
  always_comb begin
    axil_rsp.awready = q.aw_rdy;
    axil_rsp.wready  = q.w_rdy;
    axil_rsp.bvalid  = q.b_vld;
    axil_rsp.bresp   = q.b_resp;
    axil_rsp.arready = q.ar_rdy;
    axil_rsp.rvalid  = q.r_vld;
    axil_rsp.rdata   = q.r_data;
    axil_rsp.rresp   = q.r_resp;
  end
  assign gpio_out = q.outv;
  assign gpio_oe  = q.oe;

  ////////////////////////////////////////////////////////////////////////
  // checks next to the logic
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CLR_DROPS: assert property ( // [RULE1]
    wr_go && (is_leg_clr || is_fast_clr) |=>
      (q.outv & $past(clr_m)) == 32'h0000_0000)
    else $error("clear write left a selected output pin high");

  AST_CLR_KEEPS: assert property ( // [RULE2]
    wr_go && (is_leg_clr || is_fast_clr) |=>
      q.outv == ($past(q.outv) & ~$past(clr_m)))
    else $error("clear write touched pins written as zero");

  AST_CLR_NOT_GPO: assert property ( // [RULE3]
    wr_go && is_leg_clr |=>
      ((q.outv ^ $past(q.outv)) & ~$past(gpo)) == 32'h0000_0000)
    else $error("clear changed an input or secondary pin");

  AST_FAST_MASKED: assert property ( // [RULE4]
    wr_go && is_fast_clr |=>
      ((q.outv ^ $past(q.outv)) & $past(q.mask)) == 32'h0000_0000)
    else $error("fast clear changed a masked pin");

  AST_RESET_ZERO: assert property ( // [RULE5]
    $rose(aresetn) |-> q.outv == 32'h0000_0000 && !q.b_vld)
    else $error("output latch not zero after reset");

  AST_LANE_ONLY: assert property ( // [RULE18]
    wr_go && is_fast_clr && q.w_strb != 4'hF |=>
      ((q.outv ^ $past(q.outv)) & ~$past(lanes)) == 32'h0000_0000)
    else $error("partial fast clear changed an unwritten lane");

  AST_SET_HIGH: assert property ( // [RULE15]
    wr_go && wr_word == GPCLR_LEG_SET_ADDR[31:2] |=>
      q.outv == ($past(q.outv) | $past(set_m)))
    else $error("set write did not raise exactly the selected pins");

  AST_PIN_PATTERN: assert property ( // [RULE10]
    wr_go && wr_word == GPCLR_LEG_PIN_ADDR[31:2] |=>
      (q.outv & $past(pin_m)) == ($past(q.w_data) & $past(pin_m)))
    else $error("pin-value write did not drive the written pattern");

  AST_SET_READ: assert property ( // [RULE16]
    axil_req.arvalid && q.ar_rdy &&
      rd_word == GPCLR_LEG_SET_ADDR[31:2] && !wr_go |=>
      q.r_vld && q.r_data == $past(q.outv))
    else $error("set register read did not return the latch");

  AST_WRITE_ANSWER: assert property ( // [RULE9]
    wr_go |=> q.b_vld ##0 !q.aw_vld && !q.w_vld)
    else $error("write was not answered in the next cycle");

  AST_FAST_SET_READ: assert property ( // [RULE17]
    axil_req.arvalid && q.ar_rdy &&
      rd_word == GPCLR_FAST_SET_ADDR[31:2] && !wr_go |=>
      q.r_data == ($past(q.outv) & ~$past(q.mask)))
    else $error("fast set read showed a masked pin");

  AST_FAST_PIN_MASKED: assert property ( // [RULE11]
    wr_go && wr_word == GPCLR_FAST_PIN_ADDR[31:2] |=>
      ((q.outv ^ $past(q.outv)) & $past(q.mask)) == 32'h0000_0000)
    else $error("fast pin write changed a masked pin");

  AST_FAST_PIN_HALF: assert property ( // [RULE12]
    wr_go && wr_word == GPCLR_FAST_PIN_ADDR[31:2] && q.w_strb == 4'h3 |=>
      (q.outv & 32'hFFFF_0000) == ($past(q.outv) & 32'hFFFF_0000))
    else $error("lower half pin write changed an upper pin");

  AST_PIN_BYTE_ONE: assert property ( // [RULE13]
    wr_go && wr_word == GPCLR_FAST_PIN_ADDR[31:2] && q.w_strb == 4'h2 |=>
      (q.outv & 32'hFFFF_00FF) == ($past(q.outv) & 32'hFFFF_00FF))
    else $error("byte pin write changed a pin outside 15:8");

  AST_CLR_BYTE_LANE: assert property ( // [RULE6]
    wr_go && is_fast_clr && q.w_strb == 4'h2 |=>
      (q.outv & 32'hFFFF_00FF) == ($past(q.outv) & 32'hFFFF_00FF))
    else $error("byte clear changed a pin outside its lane");

  AST_CLR_UPPER_HALF: assert property ( // [RULE7]
    wr_go && is_fast_clr && q.w_strb == 4'hC |=>
      (q.outv & 32'h0000_FFFF) == ($past(q.outv) & 32'h0000_FFFF))
    else $error("upper half clear changed a lower pin");

  AST_SET_WINS: assert property ( // [RULE8]
    wr_go && wr_word == GPCLR_FAST_SET_ADDR[31:2] |=>
      (q.outv & $past(set_m)) == $past(set_m))
    else $error("latest set write did not decide the pin level");

  COV_FAST_BYTE_CLR: cover property (
    wr_go && is_fast_clr && q.w_strb == 4'h2);
  COV_FAST_HALF_CLR: cover property (
    wr_go && is_fast_clr && q.w_strb == 4'hC);
  COV_MASKED_PIN: cover property (
    wr_go && wr_word == GPCLR_FAST_PIN_ADDR[31:2] &&
      q.mask == 32'hFFFF_00FF);
  COV_SET_THEN_CLR: cover property (
    wr_go && wr_word == GPCLR_LEG_SET_ADDR[31:2] ##[1:8]
      wr_go && is_leg_clr);
  COV_FAST_SET_READ: cover property (
    axil_req.arvalid && q.ar_rdy &&
      rd_word == GPCLR_FAST_SET_ADDR[31:2]);

endmodule
`default_nettype wire

/* File: testbench/gpclr_host.sv */
/*
  gpclr_host: processor-side register bus master for the port block.
  assumes: one write and one read at most in flight, tasks called by bench.
*/
`default_nettype none
module gpclr_host
  import gpclr_pkg::*;
(
  input  wire logic            aclk,
  output var  gpclr_axil_req_t axil_req,
  input  wire gpclr_axil_rsp_t axil_rsp
);
  timeunit 1ns;
  timeprecision 100ps;

  initial axil_req = '0;

  //////////////////////////////////////////////////////////////////////////
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
    logic aw_p, w_p, b_p;
    @(posedge aclk);
    aw_p = 1'b1;
    w_p  = 1'b1;
    b_p  = 1'b1;
    axil_req.awvalid <= 1'b1;
    axil_req.awaddr  <= a;
    axil_req.wvalid  <= 1'b1;
    axil_req.wdata   <= d;
    axil_req.wstrb   <= s;
    axil_req.bready  <= 1'b1; // held until the answer is sampled
    while (aw_p || w_p || b_p) begin
      @(posedge aclk);
      if (aw_p && axil_rsp.awready) begin
        aw_p = 1'b0;
        axil_req.awvalid <= 1'b0;
      end
      if (w_p && axil_rsp.wready) begin
        w_p = 1'b0;
        axil_req.wvalid <= 1'b0;
      end
      if (b_p && axil_rsp.bvalid) begin
        b_p = 1'b0;
        axil_req.bready <= 1'b0;
      end
    end
  endtask

  // read: rready raised with the request so no answer is ever stalled
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge aclk);
    axil_req.arvalid <= 1'b1;
    axil_req.araddr  <= a;
    axil_req.rready  <= 1'b1;
    do @(posedge aclk); while (!axil_rsp.arready);
    axil_req.arvalid <= 1'b0;
    do @(posedge aclk); while (!axil_rsp.rvalid);
    d = axil_rsp.rdata;
    axil_req.rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/gpclr_port_test.sv */
/*
  gpclr_port_test: self-checking bench for the port output latch block.
  assumes: gpclr_host stands in for the processor; pads are not modelled.
*/
`default_nettype none
module gpclr_port_test
  import gpclr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic            aclk, aresetn;
  logic [31:0]     gpio_in, gpio_out, gpio_oe;
  gpclr_axil_req_t req;
  gpclr_axil_rsp_t rsp;
  logic [31:0]     out_m, dir_m, func_m, mask_m, v, d;
  logic [65:0]     exp_wr[$];
  logic [33:0]     exp_rd[$];
  // what the monitor compares, packed like the queued notes
  wire logic [65:0] wr_seen = {rsp.bresp, gpio_oe, gpio_out};
  wire logic [65:0] rd_seen = {32'h0, rsp.rresp, rsp.rdata};
  int              mismatches, tests_run, seed;
  logic [31:0]     ops[7] = '{GPCLR_LEG_SET_ADDR, GPCLR_LEG_CLR_ADDR,
    GPCLR_FAST_SET_ADDR, GPCLR_FAST_CLR_ADDR, GPCLR_FAST_PIN_ADDR,
    GPCLR_LEG_PIN_ADDR, GPCLR_FAST_MASK_ADDR};
  logic [3:0]      strbs[7] = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC};

  gpclr_port dut_u (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe));
  gpclr_host host_u (.aclk(aclk), .axil_req(req), .axil_rsp(rsp));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [65:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // model of the latch; only pins driven, unmasked and strobed may move
  task automatic wr(input logic [31:0] a, dt, input logic [3:0] s);
    logic [31:0] ln, el;
    logic [1:0]  rs;
    ln = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    el = dir_m & ~func_m & ln & ((a[31:28] == 4'h3) ? ~mask_m : '1);
    rs = GPCLR_RESP_OK;
    case ({a[31:2], 2'b00})
      GPCLR_LEG_SET_ADDR, GPCLR_FAST_SET_ADDR: out_m = out_m | (dt & el);
      GPCLR_LEG_CLR_ADDR, GPCLR_FAST_CLR_ADDR: out_m = out_m & ~(dt & el);
      GPCLR_LEG_PIN_ADDR, GPCLR_FAST_PIN_ADDR:
        out_m = (out_m & ~el) | (dt & el);
      GPCLR_LEG_DIR_ADDR, GPCLR_FAST_DIR_ADDR:
        dir_m = (dir_m & ~ln) | (dt & ln);
      GPCLR_FUNC_ADDR: func_m = (func_m & ~ln) | (dt & ln);
      GPCLR_FAST_MASK_ADDR: mask_m = (mask_m & ~ln) | (dt & ln);
      default: rs = GPCLR_RESP_ERR;
    endcase
    exp_wr.push_back({rs, dir_m & ~func_m, out_m});
    host_u.wr(a, dt, s);
  endtask

  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    host_u.rd(a, v);
  endtask

  // each taken response is matched against the oldest note
  always @(posedge aclk) begin
    if (aresetn && rsp.bvalid && req.bready)
      check(wr_seen, exp_wr.pop_front(), "write");
    if (aresetn && rsp.rvalid && req.rready)
      check(rd_seen, {32'h0, exp_rd.pop_front()}, "read");
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    gpio_in = '0;
    seed = $urandom(44);
    {out_m, dir_m, func_m, mask_m} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    gpio_in <= $urandom;
    repeat (2) @(posedge aclk);
    check({34'h0, gpio_oe, gpio_out}, 66'h0, "reset");
    rd(GPCLR_LEG_CLR_ADDR, {GPCLR_RESP_OK, 32'h0});
    rd(GPCLR_LEG_SET_ADDR, {GPCLR_RESP_OK, 32'h0});
    // pins 3:0 stay inputs and pin 4 takes its secondary function
    wr(GPCLR_LEG_DIR_ADDR, 32'hFFFF_FFF0, 4'hF);
    wr(GPCLR_FUNC_ADDR, 32'h0000_0010, 4'hF);
    rd(GPCLR_FAST_DIR_ADDR, {GPCLR_RESP_OK, dir_m});
    rd(GPCLR_FUNC_ADDR, {GPCLR_RESP_OK, func_m});
    wr(GPCLR_LEG_SET_ADDR, 32'hFFFF_FFFF, 4'hF);
    wr(GPCLR_LEG_CLR_ADDR, 32'h0F0F_0F1F, 4'hF);
    // set then clear back to back, clear through each byte register
    for (int k = 0; k < 4; k++) begin
      wr(GPCLR_FAST_SET_ADDR, 32'hFFFF_FFFF, 4'hF);
      wr(GPCLR_FAST_CLR_ADDR + 32'(k), 32'hA5A5_A5A5, 4'h1 << k);
    end
    wr(GPCLR_FAST_CLR_ADDR + 32'h2, 32'h3C3C_0000, 4'hC);
    wr(GPCLR_FAST_CLR_ADDR, 32'h0000_FFFF, 4'h3);
    wr(GPCLR_FAST_MASK_ADDR, 32'hFFFF_00FF, 4'hF);
    wr(GPCLR_FAST_CLR_ADDR, 32'hFFFF_FFFF, 4'hF);
    wr(GPCLR_FAST_PIN_ADDR, 32'h0000_A500, 4'hF);
    // fast reads hide masked pins as zero
    d = dir_m & ~func_m;
    v = ((out_m & d) | (gpio_in & ~d)) & ~mask_m;
    rd(GPCLR_FAST_SET_ADDR, {GPCLR_RESP_OK, out_m & ~mask_m});
    rd(GPCLR_FAST_PIN_ADDR, {GPCLR_RESP_OK, v});
    rd(GPCLR_FAST_MASK_ADDR, {GPCLR_RESP_OK, mask_m});
    rd(GPCLR_FAST_CLR_ADDR + 32'h1, {GPCLR_RESP_OK, 32'h0});
    wr(GPCLR_FAST_MASK_ADDR, 32'h0, 4'hF);
    wr(GPCLR_FAST_MASK_ADDR, 32'hFFFF_00FF, 4'h3);
    wr(GPCLR_FAST_PIN_ADDR, 32'h5A5A_A500, 4'h3);
    wr(GPCLR_FAST_MASK_ADDR, 32'h0, 4'hF);
    wr(GPCLR_FAST_PIN_ADDR + 32'h1, 32'h0000_A500, 4'h2);
    // partial legacy update by read, merge and write back
    d = dir_m & ~func_m;
    rd(GPCLR_LEG_PIN_ADDR, {GPCLR_RESP_OK, (out_m & d) | (gpio_in & ~d)});
    d = (v & 32'hFFFF_00FF) | 32'h0000_A500;
    wr(GPCLR_LEG_PIN_ADDR, d, 4'hF);
    wr(32'hE002_8020, 32'hFFFF_FFFF, 4'hF); // unmapped, no effect
    rd(32'hE002_8020, {GPCLR_RESP_ERR, 32'h0});
    // random mix of set, clear, pin and mask writes on random lanes
    repeat (40) begin
      wr(ops[$urandom % 7], $urandom, strbs[$urandom % 7]);
      rd(GPCLR_LEG_SET_ADDR, {GPCLR_RESP_OK, out_m});
    end
    repeat (4) @(posedge aclk);
    give_verdict();
  end

  // watchdog: the run needs well under a tenth of this span
  initial begin
    #80000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
